// ---- hw/ccx_pkg.sv ----
/*
  Shared constants and carriers for the control-channel access block.
  Assumes a single 50 MHz system clock and the synchronous reset of the block.
*/
package ccx_pkg;

  localparam int DEV_W   = 7;
  localparam int RADDR_W = 16;
  localparam int DATA_W  = 8;

  // Internal register offsets on the 16-bit register address space
  localparam logic [15:0] REG_SUB_ADDR   = 16'h0000;
  localparam logic [15:0] REG_CHAN_CTRL  = 16'h0001;
  localparam logic [15:0] REG_PROTO_STAT = 16'h0002;
  localparam logic [15:0] REG_SRC_ID     = 16'h0003;
  localparam logic [15:0] REG_GEN_BASE   = 16'h0010;

  // Field positions inside the channel control register
  localparam int CTRL_REM_DIS = 0;
  localparam int CTRL_PIN_DIS = 1;
  localparam int CTRL_LOCK    = 2;
  localparam int CTRL_ARQ_OFF = 3;

  // Values after reset
  localparam logic [7:0] CHAN_CTRL_RESET = 8'h00;
  localparam logic [6:0] SUB_ADDR_RESET  = 7'h00;

  // Cycle counts
  localparam logic [1:0]  STRAP_SETTLE_CYCLES = 2'h3;
  localparam logic [15:0] RSP_TIMEOUT_DEFAULT = 16'h0800;

  typedef struct packed {
    logic [DEV_W-1:0]   dev;
    logic [RADDR_W-1:0] reg_addr;
    logic               write;
    logic [DATA_W-1:0]  data;
  } ccx_req_s;

  typedef struct packed {
    logic              ack;
    logic              collision;
    logic [DATA_W-1:0] data;
  } ccx_rsp_s;

  typedef struct packed {
    logic     is_rsp;
    logic     ctrl;
    logic     protect;
    ccx_req_s req;
    ccx_rsp_s rsp;
  } ccx_pkt_s;

  typedef enum {
    ST_IDLE,
    ST_SEND,
    ST_FWD_WAIT,
    ST_PIN_SEND,
    ST_PIN_WAIT
  } ccx_state_e;

endpackage : ccx_pkg

// ---- hw/ccx_access.sv ----
/*
  Control-channel access block: strap capture, own register file, forwarding of
  control-channel traffic over the serial link and repeating of remote traffic on
  the local pins. Assumes a protocol front end that turns pin traffic into
  request strobes and a link layer that carries packets; both on clk_sys.
*/
// Functional notes
// - Latch protocol strap once after power-up
// - All registers reachable, 16-bit register addresses
// - Forward to far side only when locked
// - Address strap sets address and source identifier
// - Answer only at newly written address
// - Concurrent mains: NACK in I2C, collision UART
// - Remote disable blocks forwarding across link
// - Lock bit rejects writes until power-down
// - Local pin disable detaches pins from channel
// - Link packets protected by retransmission and CRC
// - Protection off only locally while unlocked
// - Pass-through never touches internal registers
// - Respond only at own subordinate address
module ccx_access
  import ccx_pkg::*;
#(
  parameter int GEN_REGS           = 16,
  parameter int RSP_TIMEOUT_CYCLES = RSP_TIMEOUT_DEFAULT
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             reset,
  // Power-down pin, and straps sampled at power-up
  input  wire logic             power_down_n,
  input  wire logic             protocol_select_strap,
  input  wire logic [DEV_W-1:0] addr_strap,
  // Link state
  input  wire logic             link_locked,
  // Local main requests
  input  wire logic             loc_req_valid,
  output logic                  loc_req_ready,
  input  wire ccx_req_s         loc_req,
  output logic                  loc_rsp_valid,
  output ccx_rsp_s              loc_rsp,
  // Serial link packets
  output logic                  link_tx_valid,
  input  wire logic             link_tx_ready,
  output ccx_pkt_s              link_tx,
  input  wire logic             link_rx_valid,
  input  wire ccx_pkt_s         link_rx,
  // Repeat of remote traffic on local pins
  output logic                  pin_req_valid,
  input  wire logic             pin_req_ready,
  output ccx_req_s              pin_req,
  input  wire logic             pin_rsp_valid,
  input  wire ccx_rsp_s         pin_rsp,
  // Status
  output logic                  straps_ready,
  output logic                  i2c_mode,
  output logic [DEV_W-1:0]      subordinate_address,
  output logic [DEV_W-1:0]      default_source_identifier,
  output logic                  remote_chan_disable,
  output logic                  local_pin_disable,
  output logic                  config_locked,
  output logic                  arq_crc_enable
);

  // Pin synchronisers, three stages each
  logic [DEV_W:0] strap_s1, strap_s2, strap_s3;
  logic [2:0]     pd_sync;
  logic           pd_level;
  logic           rst_all;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      strap_s1 <= '0;
      strap_s2 <= '0;
      strap_s3 <= '0;
      pd_sync  <= 3'h7;
      pd_level <= 1'b1;
    end else begin
      strap_s1 <= {protocol_select_strap, addr_strap};
      strap_s2 <= strap_s1;
      strap_s3 <= strap_s2;
      pd_sync  <= {pd_sync[1:0], power_down_n};
      if (pd_sync[1] == pd_sync[2]) begin
        pd_level <= pd_sync[2];
      end
    end
  end

  // Power-down clears all state past the synchronisers, lock bit included
  assign rst_all = reset | ~pd_level;

  // Block state
  ccx_state_e       state, next_state;
  logic [1:0]       strap_cnt, next_strap_cnt;
  logic             strap_done, next_strap_done;
  logic             next_i2c_mode;
  logic [DEV_W-1:0] sub_addr, next_sub_addr;
  logic [DEV_W-1:0] src_id, next_src_id;
  logic [7:0]       chan_ctrl, next_chan_ctrl;
  logic [7:0]       gen_regs [GEN_REGS];
  logic [7:0]       next_gen_regs [GEN_REGS];
  logic [15:0]      wait_cnt, next_wait_cnt;
  logic             next_loc_rsp_valid;
  ccx_rsp_s         next_loc_rsp;
  logic             next_link_tx_valid;
  ccx_pkt_s         next_link_tx;
  logic             next_pin_req_valid;
  ccx_req_s         next_pin_req;

  logic             rem_dis, pin_dis, lock;
  logic             remote_in;
  ccx_req_s         acc_req;
  logic             acc_local;
  ccx_rsp_s         acc_rsp;
  logic             wr_ok;

  assign rem_dis = chan_ctrl[CTRL_REM_DIS];
  assign pin_dis = chan_ctrl[CTRL_PIN_DIS];
  assign lock    = chan_ctrl[CTRL_LOCK];

  // Whether an address lies inside the general register window
  function automatic logic gen_hit(input logic [15:0] a);
    logic [15:0] off;
    off = a - REG_GEN_BASE;
    return (a >= REG_GEN_BASE) && (off < 16'(GEN_REGS));
  endfunction : gen_hit

  function automatic logic [7:0] reg_read(input logic [15:0] a);
    logic [7:0] r;
    logic [15:0] off;
    r   = 8'h00;
    off = a - REG_GEN_BASE;
    if (a == REG_SUB_ADDR) begin
      r = {1'b0, sub_addr};
    end else if (a == REG_CHAN_CTRL) begin
      r = chan_ctrl;
    end else if (a == REG_PROTO_STAT) begin
      r = {7'h00, i2c_mode};
    end else if (a == REG_SRC_ID) begin
      r = {1'b0, src_id};
    end else if (gen_hit(a)) begin
      r = gen_regs[off[$clog2(GEN_REGS)-1:0]];
    end
    return r;
  endfunction : reg_read

  // Incoming link traffic wins the idle slot over the local main
  assign remote_in = link_rx_valid && !link_rx.is_rsp && link_rx.ctrl;
  assign loc_req_ready = strap_done && (state == ST_IDLE) && !remote_in;

  always_comb begin
    acc_local     = !(state == ST_IDLE && remote_in);
    acc_req       = acc_local ? loc_req : link_rx.req;
    wr_ok         = !lock;
    acc_rsp.ack       = acc_req.write ? wr_ok : 1'b1;
    acc_rsp.collision = 1'b0;
    acc_rsp.data      = reg_read(acc_req.reg_addr);
  end

  always_comb begin
    logic [15:0] off;
    logic        do_acc;
    off                = acc_req.reg_addr - REG_GEN_BASE;
    do_acc             = 1'b0;
    next_state         = state;
    next_strap_cnt     = strap_cnt;
    next_strap_done    = strap_done;
    next_i2c_mode      = i2c_mode;
    next_sub_addr      = sub_addr;
    next_src_id        = src_id;
    next_chan_ctrl     = chan_ctrl;
    next_gen_regs      = gen_regs;
    next_wait_cnt      = wait_cnt;
    next_loc_rsp_valid = 1'b0;
    next_loc_rsp       = loc_rsp;
    next_link_tx_valid = link_tx_valid;
    next_link_tx       = link_tx;
    next_pin_req_valid = pin_req_valid;
    next_pin_req       = pin_req;

    // Straps taken once, after the synchroniser has filled and settled
    if (!strap_done) begin
      if (strap_cnt != STRAP_SETTLE_CYCLES) begin
        next_strap_cnt = strap_cnt + 2'h1;
      end else if (strap_s2 == strap_s3) begin
        next_strap_done = 1'b1;
        next_i2c_mode   = strap_s3[DEV_W];
        next_sub_addr   = strap_s3[DEV_W-1:0];
        next_src_id     = strap_s3[DEV_W-1:0];
      end
    end

    unique case (state)
      ST_IDLE: begin
        next_wait_cnt = '0;
        if (strap_done && remote_in) begin
          // Pass-through packets carry ctrl low and never get here
          next_link_tx         = '0;
          next_link_tx.is_rsp  = 1'b1;
          next_link_tx.ctrl    = 1'b1;
          next_link_tx.protect = arq_crc_enable;
          next_link_tx.req     = link_rx.req;
          if (rem_dis) begin
            next_state = ST_IDLE;
          end else if (link_rx.req.dev == sub_addr) begin
            do_acc             = 1'b1;
            next_link_tx.rsp   = acc_rsp;
            next_link_tx_valid = 1'b1;
            next_state         = ST_SEND;
          end else if (pin_dis) begin
            next_link_tx_valid = 1'b1;
            next_state         = ST_SEND;
          end else begin
            next_pin_req       = link_rx.req;
            next_pin_req_valid = 1'b1;
            next_state         = ST_PIN_SEND;
          end
        end else if (loc_req_valid && loc_req_ready && !pin_dis) begin
          next_loc_rsp = '0;
          if (loc_req.dev == sub_addr) begin
            do_acc             = 1'b1;
            next_loc_rsp       = acc_rsp;
            next_loc_rsp_valid = 1'b1;
          end else if (rem_dis || !link_locked) begin
            next_loc_rsp_valid = 1'b1;
          end else begin
            next_link_tx         = '0;
            next_link_tx.ctrl    = 1'b1;
            next_link_tx.protect = arq_crc_enable;
            next_link_tx.req     = loc_req;
            next_link_tx_valid   = 1'b1;
            next_state           = ST_SEND;
          end
        end
      end
      ST_SEND: begin
        if (link_tx_ready) begin
          next_link_tx_valid = 1'b0;
          next_state         = link_tx.is_rsp ? ST_IDLE : ST_FWD_WAIT;
        end
      end
      ST_FWD_WAIT: begin
        next_wait_cnt = wait_cnt + 16'h0001;
        next_loc_rsp  = '0;
        if (link_rx_valid && link_rx.is_rsp) begin
          next_loc_rsp       = link_rx.rsp;
          next_loc_rsp_valid = 1'b1;
          next_state         = ST_IDLE;
        end else if (remote_in) begin
          // Far main active too: fail ours, drop theirs
          next_loc_rsp.collision = !i2c_mode;
          next_loc_rsp_valid     = 1'b1;
          next_state             = ST_IDLE;
        end else if (wait_cnt == 16'(RSP_TIMEOUT_CYCLES - 1)) begin
          next_loc_rsp_valid = 1'b1;
          next_state         = ST_IDLE;
        end
      end
      ST_PIN_SEND: begin
        if (pin_req_ready) begin
          next_pin_req_valid = 1'b0;
          next_state         = ST_PIN_WAIT;
        end
      end
      ST_PIN_WAIT: begin
        next_wait_cnt = wait_cnt + 16'h0001;
        if (pin_rsp_valid || wait_cnt == 16'(RSP_TIMEOUT_CYCLES - 1)) begin
          next_link_tx.rsp   = pin_rsp_valid ? pin_rsp : '0;
          next_link_tx_valid = 1'b1;
          next_state         = ST_SEND;
        end
      end
    endcase

    // Register writes from either the local main or the far side
    if (do_acc && acc_req.write && wr_ok) begin
      if (acc_req.reg_addr == REG_SUB_ADDR) begin
        next_sub_addr = acc_req.data[DEV_W-1:0];
      end else if (acc_req.reg_addr == REG_CHAN_CTRL) begin
        next_chan_ctrl[CTRL_REM_DIS] = acc_req.data[CTRL_REM_DIS];
        next_chan_ctrl[CTRL_PIN_DIS] = acc_req.data[CTRL_PIN_DIS];
        next_chan_ctrl[CTRL_LOCK]    = acc_req.data[CTRL_LOCK];
        if (acc_local && !link_locked) begin
          next_chan_ctrl[CTRL_ARQ_OFF] = acc_req.data[CTRL_ARQ_OFF];
        end
      end else if (acc_req.reg_addr == REG_SRC_ID) begin
        next_src_id = acc_req.data[DEV_W-1:0];
      end else if (gen_hit(acc_req.reg_addr)) begin
        next_gen_regs[off[$clog2(GEN_REGS)-1:0]] = acc_req.data;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst_all) begin
      state         <= ST_IDLE;
      strap_cnt     <= 2'h0;
      strap_done    <= 1'b0;
      i2c_mode      <= 1'b0;
      sub_addr      <= SUB_ADDR_RESET;
      src_id        <= SUB_ADDR_RESET;
      chan_ctrl     <= CHAN_CTRL_RESET;
      wait_cnt      <= 16'h0000;
      loc_rsp_valid <= 1'b0;
      loc_rsp       <= '0;
      link_tx_valid <= 1'b0;
      link_tx       <= '0;
      pin_req_valid <= 1'b0;
      pin_req       <= '0;
      for (int i = 0; i < GEN_REGS; i++) begin
        gen_regs[i] <= 8'h00;
      end
    end else begin
      state         <= next_state;
      strap_cnt     <= next_strap_cnt;
      strap_done    <= next_strap_done;
      i2c_mode      <= next_i2c_mode;
      sub_addr      <= next_sub_addr;
      src_id        <= next_src_id;
      chan_ctrl     <= next_chan_ctrl;
      wait_cnt      <= next_wait_cnt;
      loc_rsp_valid <= next_loc_rsp_valid;
      loc_rsp       <= next_loc_rsp;
      link_tx_valid <= next_link_tx_valid;
      link_tx       <= next_link_tx;
      pin_req_valid <= next_pin_req_valid;
      pin_req       <= next_pin_req;
      gen_regs      <= next_gen_regs;
    end
  end

  assign straps_ready              = strap_done;
  assign subordinate_address       = sub_addr;
  assign default_source_identifier = src_id;
  assign remote_chan_disable       = rem_dis;
  assign local_pin_disable         = pin_dis;
  assign config_locked             = lock;
  assign arq_crc_enable            = !chan_ctrl[CTRL_ARQ_OFF];

endmodule : ccx_access

// ---- verif/ccx_access_asserts.sv ----
/*
  Checker for ccx_access, bound to the ports of every instance.
  Assumes one clock and power_down_n high except for deliberate pulses.
*/
module ccx_access_asserts
  import ccx_pkg::*;
(
  // Clock and reset
  input wire logic             clk_sys,
  input wire logic             reset,
  // Inputs
  input wire logic             power_down_n,
  input wire logic             link_locked,
  input wire logic             loc_req_valid,
  input wire ccx_req_s         loc_req,
  input wire logic             link_tx_ready,
  // Outputs
  input wire logic             loc_req_ready,
  input wire logic             loc_rsp_valid,
  input wire ccx_rsp_s         loc_rsp,
  input wire logic             link_tx_valid,
  input wire ccx_pkt_s         link_tx,
  input wire logic             straps_ready,
  input wire logic             i2c_mode,
  input wire logic [DEV_W-1:0] subordinate_address,
  input wire logic [DEV_W-1:0] default_source_identifier,
  input wire logic             remote_chan_disable,
  input wire logic             local_pin_disable,
  input wire logic             config_locked,
  input wire logic             arq_crc_enable
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic tk;
  logic own;
  logic wr_own;
  // Dropped requests get no answer, so they are left out
  assign tk     = loc_req_valid & loc_req_ready & ~local_pin_disable;
  assign own    = loc_req.dev == subordinate_address;
  assign wr_own = tk & own & loc_req.write;

  a_own_answer: assert property (tk && own && !(loc_req.write && config_locked) |=> loc_rsp_valid && loc_rsp.ack)
    else $error("own address access not acknowledged next cycle");
  a_locked_write: assert property (wr_own && config_locked |=>
    loc_rsp_valid && !loc_rsp.ack && config_locked && $stable(subordinate_address))
    else $error("write accepted while configuration locked");
  a_unfwd_nack: assert property (tk && !own && (!link_locked || remote_chan_disable) |=>
    loc_rsp_valid && !loc_rsp.ack)
    else $error("unforwardable access not refused next cycle");
  a_fwd_locked: assert property ($rose(link_tx_valid) && !link_tx.is_rsp |->
    $past(link_locked) && !$past(remote_chan_disable))
    else $error("request forwarded while unlocked or disabled");
  a_fwd_protect: assert property (link_tx_valid && !link_tx.is_rsp |-> link_tx.ctrl && link_tx.protect == arq_crc_enable)
    else $error("forwarded packet protection flag wrong");
  a_tx_hold: assert property (link_tx_valid && !link_tx_ready |=> link_tx_valid && $stable(link_tx))
    else $error("link packet changed before it was taken");
  a_arq_local: assert property ($fell(arq_crc_enable) |-> !$past(link_locked) && $past(wr_own))
    else $error("protection turned off without local unlocked write");
  a_lock_sticky: assert property ($fell(config_locked) |-> !$past(power_down_n, 2) ||
    !$past(power_down_n, 3) || !$past(power_down_n, 4) || !$past(power_down_n, 5))
    else $error("lock cleared without power-down");
  a_strap_hold: assert property (straps_ready && $past(straps_ready) |-> $stable(i2c_mode))
    else $error("protocol mode changed after capture");
  a_src_id: assert property ($rose(straps_ready) |-> default_source_identifier == subordinate_address)
    else $error("source identifier differs from strap address");

  c_forward: cover property (tk && !own && link_locked && !remote_chan_disable);
  c_clash: cover property (loc_rsp_valid && !loc_rsp.ack && loc_rsp.collision == !i2c_mode);
  c_unlock: cover property ($fell(config_locked));
endmodule : ccx_access_asserts

bind ccx_access ccx_access_asserts u_ccx_access_asserts (.clk_sys, .reset, .power_down_n, .link_locked,
  .loc_req_valid, .loc_req, .link_tx_ready, .loc_req_ready, .loc_rsp_valid, .loc_rsp, .link_tx_valid, .link_tx,
  .straps_ready, .i2c_mode, .subordinate_address, .default_source_identifier, .remote_chan_disable,
  .local_pin_disable, .config_locked, .arq_crc_enable);

// ---- verif/ccx_far_end.sv ----
/*
  Far end of the serial link: takes forwarded requests, answers them.
  Assumes packets from ccx_access on clk_sys; one transaction at a time.
*/
module ccx_far_end
  import ccx_pkg::*;
(
  // Clock and scenario knobs
  input  wire logic     clk_sys,
  input  wire logic     slow,
  input  wire logic     collide,
  input  wire logic     poke,
  input  wire ccx_req_s poke_req,
  // Link
  input  wire logic     link_tx_valid,
  input  wire ccx_pkt_s link_tx,
  output logic          link_tx_ready,
  output logic          link_rx_valid,
  output ccx_pkt_s      link_rx,
  // Last answer to a request sent from this end
  output ccx_rsp_s      got_rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  int       cnt   = 0;
  logic [1:0] stall = 2'h0;
  ccx_req_s hold  = '0;
  logic     poked = 1'b0;
  initial begin
    got_rsp       = '0;
    link_tx_ready = 1'b0;
    link_rx_valid = 1'b0;
    link_rx       = '0;
  end
  always @(posedge clk_sys) begin
    stall         <= stall + 2'h1;
    link_rx_valid <= 1'b0;
    // Idle lines never keep a stale packet
    link_rx       <= ~link_rx;
    link_tx_ready <= 1'b0;
    poked         <= poke;
    if (cnt > 0) begin
      cnt <= cnt - 1;
      // One answer per outstanding request; a clash is sent only on command
      if (cnt == 1) begin
        link_rx_valid <= 1'b1;
        link_rx       <= '{!collide, 1'b1, 1'b1, hold, '{1'b1, 1'b0, hold.reg_addr[7:0] ^ 8'hA5}};
      end
    end else if (link_tx_ready && link_tx_valid) begin
      if (link_tx.is_rsp) begin
        got_rsp <= link_tx.rsp;
      end else begin
        hold <= link_tx.req;
        cnt  <= slow ? 12 : 2;
      end
    end else if (link_tx_valid) begin
      link_tx_ready <= !slow || stall == 2'h3;
    end else if (poke && !poked) begin
      // One request from this end per rising edge of poke
      link_rx_valid <= 1'b1;
      link_rx       <= '{1'b0, 1'b1, 1'b1, poke_req, '{1'b0, 1'b0, 8'h00}};
    end
  end
endmodule : ccx_far_end

// ---- verif/ccx_access_tb.sv ----
/*
  Self-checking bench for ccx_access with the far-end link model.
  Assumes I2C strap, then UART after power-down; the local pin repeat side is left idle.
*/
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin bad_count++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module ccx_access_tb
  import ccx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, reset = 1, power_down_n = 1, link_locked = 0, slow = 0, collide = 0, sel = 1, poke = 0;
  logic local_pin_disable;
  ccx_req_s poke_req = '0;
  ccx_rsp_s got_rsp;
  logic loc_req_valid = 0, loc_req_ready, loc_rsp_valid, link_tx_valid, link_tx_ready, link_rx_valid;
  logic straps_ready, i2c_mode, remote_chan_disable, config_locked, arq_crc_enable;
  logic [6:0] strap, far, nxt, subordinate_address, default_source_identifier;
  logic [31:0] seed = 32'h4801423A;
  ccx_req_s loc_req = '0;
  ccx_rsp_s loc_rsp, rsp;
  ccx_pkt_s link_tx, link_rx;
  int bad_count = 0, n_tests = 0;

  ccx_access #(.RSP_TIMEOUT_CYCLES(64)) u_ccx_access (.clk_sys, .reset, .power_down_n,
    .protocol_select_strap(sel), .addr_strap(strap), .link_locked, .loc_req_valid, .loc_req_ready, .loc_req,
    .loc_rsp_valid, .loc_rsp, .link_tx_valid, .link_tx_ready, .link_tx, .link_rx_valid, .link_rx,
    .pin_req_valid(), .pin_req_ready(1'b1), .pin_req(), .pin_rsp_valid(1'b0), .pin_rsp('0), .straps_ready,
    .i2c_mode, .subordinate_address, .default_source_identifier, .remote_chan_disable, .local_pin_disable,
    .config_locked, .arq_crc_enable);
  ccx_far_end u_ccx_far_end (.clk_sys, .slow, .collide, .poke, .poke_req, .link_tx_valid, .link_tx,
    .link_tx_ready, .link_rx_valid, .link_rx, .got_rsp);

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [7:0] far_data(input logic [15:0] a);
    return a[7:0] ^ 8'hA5;
  endfunction : far_data

  task automatic conclude;
    if (bad_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  task automatic settle;
    int k;
    k = 0;
    while (straps_ready !== 1'b1 && k < 30) begin
      @(posedge clk_sys);
      #2;
      k++;
    end
  endtask : settle
  task automatic acc(input logic [6:0] d, input logic [15:0] a, input logic w, input logic [7:0] v,
                     input logic ea, input logic [7:0] ed);
    int k;
    k = 0;
    // Valid low for at least one edge between requests
    @(posedge clk_sys);
    #2;
    loc_req       = '{d, a, w, v};
    loc_req_valid = 1'b1;
    while (loc_req_ready !== 1'b1 && k < 99) begin
      @(posedge clk_sys);
      #2;
      k++;
    end
    @(posedge clk_sys);
    #2;
    loc_req_valid = 1'b0;
    while (loc_rsp_valid !== 1'b1 && k < 199) begin
      @(posedge clk_sys);
      #2;
      k++;
    end
    rsp = loc_rsp;
    `CHK("answer", 1'b1, loc_rsp_valid)
    `CHK("ack", ea, rsp.ack)
    if (!w && ea) `CHK("data", ed, rsp.data)
  endtask : acc
  // Request from the far main; slow far end takes the answer within ten edges
  task automatic remote(input ccx_req_s r);
    poke_req = r;
    poke     = 1'b1;
    repeat (10) @(posedge clk_sys);
    #2;
    poke = 1'b0;
    @(posedge clk_sys);
    #2;
  endtask : remote

  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  // Whole run needs well under 3000 cycles
  initial begin
    #100us;
    bad_count++;
    conclude();
  end

  initial begin
    seed  = lfsr(seed);
    strap = seed[6:0] | 7'h08;
    far   = strap ^ 7'h40;
    nxt   = strap ^ 7'h15;
    repeat (3) @(posedge clk_sys);
    #2;
    reset = 1'b0;
    settle();
    `CHK("mode", 1'b1, i2c_mode)
    `CHK("addr", strap, subordinate_address)
    `CHK("srcid", strap, default_source_identifier)
    `CHK("arq", 1'b1, arq_crc_enable)
    acc(strap, REG_PROTO_STAT, 1'b1, 8'h00, 1'b1, 8'h00);
    acc(strap, REG_PROTO_STAT, 1'b0, 8'h00, 1'b1, 8'h01);
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      acc(strap, REG_GEN_BASE + 16'(seed[3:0]), 1'b1, seed[15:8], 1'b1, 8'h00);
      acc(strap, REG_GEN_BASE + 16'(seed[3:0]), 1'b0, 8'h00, 1'b1, seed[15:8]);
    end
    acc(strap, REG_GEN_BASE, 1'b1, 8'h5A, 1'b1, 8'h00);
    acc(strap, 16'hFF00, 1'b0, 8'h00, 1'b1, 8'h00);
    acc(far, 16'h1234, 1'b0, 8'h00, 1'b0, 8'h00);
    acc(strap, REG_CHAN_CTRL, 1'b1, 8'h08, 1'b1, 8'h00);
    `CHK("arq", 1'b0, arq_crc_enable)
    acc(strap, REG_CHAN_CTRL, 1'b1, 8'h00, 1'b1, 8'h00);
    `CHK("arq", 1'b1, arq_crc_enable)
    link_locked = 1'b1;
    for (int i = 0; i < 2; i++) begin
      slow = i[0];
      acc(far, 16'h1234 + 16'(i), 1'b0, 8'h00, 1'b1, far_data(16'h1234 + 16'(i)));
    end
    remote('{strap, REG_GEN_BASE + 16'h0001, 1'b1, 8'h3C});
    `CHK("rem ack", 1'b1, got_rsp.ack)
    acc(strap, REG_GEN_BASE + 16'h0001, 1'b0, 8'h00, 1'b1, 8'h3C);
    collide = 1'b1;
    acc(far, 16'h0042, 1'b0, 8'h00, 1'b0, 8'h00);
    `CHK("clash", 1'b0, rsp.collision)
    collide = 1'b0;
    acc(strap, REG_CHAN_CTRL, 1'b1, 8'h08, 1'b1, 8'h00);
    `CHK("arq", 1'b1, arq_crc_enable)
    acc(strap, REG_CHAN_CTRL, 1'b1, 8'h01, 1'b1, 8'h00);
    `CHK("remdis", 1'b1, remote_chan_disable)
    acc(far, 16'h1234, 1'b0, 8'h00, 1'b0, 8'h00);
    acc(strap, REG_CHAN_CTRL, 1'b1, 8'h00, 1'b1, 8'h00);
    link_locked = 1'b0;
    acc(strap, REG_SUB_ADDR, 1'b1, {1'b0, nxt}, 1'b1, 8'h00);
    acc(strap, REG_SUB_ADDR, 1'b0, 8'h00, 1'b0, 8'h00);
    acc(nxt, REG_SUB_ADDR, 1'b0, 8'h00, 1'b1, {1'b0, nxt});
    acc(nxt, REG_CHAN_CTRL, 1'b1, 8'h04, 1'b1, 8'h00);
    `CHK("lock", 1'b1, config_locked)
    acc(nxt, REG_GEN_BASE, 1'b1, 8'hC3, 1'b0, 8'h00);
    acc(nxt, REG_CHAN_CTRL, 1'b1, 8'h00, 1'b0, 8'h00);
    acc(nxt, REG_GEN_BASE, 1'b0, 8'h00, 1'b1, 8'h5A);
    power_down_n = 1'b0;
    sel          = 1'b0;
    repeat (6) @(posedge clk_sys);
    #2;
    power_down_n = 1'b1;
    settle();
    `CHK("lock", 1'b0, config_locked)
    `CHK("addr", strap, subordinate_address)
    `CHK("mode", 1'b0, i2c_mode)
    link_locked = 1'b1;
    collide     = 1'b1;
    acc(far, 16'h0042, 1'b0, 8'h00, 1'b0, 8'h00);
    `CHK("clash", 1'b1, rsp.collision)
    collide = 1'b0;
    acc(strap, REG_CHAN_CTRL, 1'b1, 8'h02, 1'b1, 8'h00);
    `CHK("pindis", 1'b1, local_pin_disable)
    remote('{far, 16'h1234, 1'b0, 8'h00});
    `CHK("rem ack", 1'b0, got_rsp.ack)
    remote('{strap, REG_CHAN_CTRL, 1'b0, 8'h00});
    `CHK("rem ack", 1'b1, got_rsp.ack)
    `CHK("rem data", 8'h02, got_rsp.data)
    conclude();
  end
endmodule : ccx_access_tb
